// [logic/hse_consts.svh]
// Shared constants for the half-space evaluator and its rendering-processor end
`ifndef HSE_CONSTS_SVH
`define HSE_CONSTS_SVH

`define HSE_COORD_W 16
`define HSE_DELTA_W 17
`define HSE_PIX_W 13
`define HSE_ACC_W 36
`define HSE_SUB_SHIFT 3
`define HSE_GRID 4
`define HSE_SITES 16
`define HSE_ARRAY_SPAN 16'h0020
`define HSE_SUB_MASK 16'hfff8

`endif

// [logic/hse_pkg.sv]
// Types and arithmetic helper shared by both ends of the half-space evaluator
`include "hse_consts.svh"

package hse_pkg;

    typedef logic signed [`HSE_COORD_W-1:0] hse_coord_t;
    typedef logic signed [`HSE_DELTA_W-1:0] hse_delta_t;
    typedef logic signed [`HSE_ACC_W-1:0] hse_acc_t;
    typedef logic signed [`HSE_PIX_W-1:0] hse_pix_t;
    typedef logic [`HSE_SITES-1:0] hse_mask_t;

    typedef enum logic [1:0] {HSE_D_EMPTY, HSE_D_HELD} hse_dev_state_t;

    typedef enum logic [2:0] {HSE_H_IDLE, HSE_H_EDGE, HSE_H_LOAD, HSE_H_TERM, HSE_H_EVAL} hse_host_state_t;

    // Operands arrive sign-extended to the accumulator width, so truncation is exact
    function automatic hse_acc_t hse_mul(input hse_acc_t a, input hse_acc_t b);
        return hse_acc_t'(a * b);
    endfunction : hse_mul

endpackage : hse_pkg

// [logic/hse_link_if.sv]
// Link between the rendering processor end and the half-space evaluator end
`timescale 1ns/1ps

interface hse_link_if;
    import hse_pkg::*;

    logic load;
    hse_delta_t dx;
    hse_delta_t dy;
    logic eval;
    hse_acc_t hconst;
    logic res_valid;
    hse_mask_t res_mask;
    logic held;

    modport dev (
        input load,
        input dx,
        input dy,
        input eval,
        input hconst,
        output res_valid,
        output res_mask,
        output held
    );

    modport host (
        output load,
        output dx,
        output dy,
        output eval,
        output hconst,
        input res_valid,
        input res_mask,
        input held
    );

endinterface : hse_link_if

// [logic/hse_site.sv]
// One site cell: stored site value, adder against the broadcast constant, sign flop
`timescale 1ns/1ps
`include "hse_consts.svh"

module hse_site (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic load_i,
    input hse_pkg::hse_acc_t site_val_i,
    input wire logic eval_i,
    input hse_pkg::hse_acc_t hconst_i,
    output logic left_o
);
    import hse_pkg::*;

    hse_acc_t val_q;
    hse_acc_t val_d;
    logic left_q;
    logic left_d;
    hse_acc_t sum;

    always_comb begin
        val_d = val_q;
        left_d = left_q;
        sum = val_q + hconst_i;
        if (load_i) begin
            val_d = site_val_i;
        end
        if (eval_i) begin
            // Zero (on the edge) and positive (right of edge) both give 0
            left_d = sum[`HSE_ACC_W-1];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            val_q <= '0;
            left_q <= 1'b0;
        end else begin
            val_q <= val_d;
            left_q <= left_d;
        end
    end

    assign left_o = left_q;

endmodule : hse_site

// [logic/hse_evaluator.sv]
// Half-space evaluator: sixteen site cells judging one directed edge in parallel
`timescale 1ns/1ps
`include "hse_consts.svh"

module hse_evaluator #(
    parameter int CNT_W = 16
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    hse_link_if.dev link,
    output hse_pkg::hse_mask_t side_mask_o,
    output logic side_valid_o,
    output logic edge_held_o,
    output logic [CNT_W-1:0] array_cnt_o
);
    import hse_pkg::*;

    // ----------------------------------------------------------------
    // Request qualification
    // ----------------------------------------------------------------

    hse_dev_state_t state_q;
    hse_dev_state_t state_d;
    logic eval_ok;
    logic load_ok;

    // A new edge always wins over an evaluation in the same cycle, since
    // that evaluation would mix the old site values with a new constant.
    // A refused evaluation leaves the mask untouched and valid low, and the counter too unless
    // a load in the same cycle clears it, so a host that fires too early simply sees no result
    assign load_ok = link.load;
    assign eval_ok = link.eval && !link.load && (state_q == HSE_D_HELD);

    // ----------------------------------------------------------------
    // Site value generation
    // ----------------------------------------------------------------

    // Deltas arrive as 17-bit values; sign-extending into 36 bits keeps
    // every site value and sum in range for any legal coordinates.
    // Budget: a delta and a coordinate difference each need 17 bits,
    // so a product fits in 34 bits and the sum of two products in 35;
    // the last bit covers the site offsets and the array steps.
    // A narrower datapath would save area but could flip the sign far
    // from the origin, and nothing downstream would notice.
    // Casts make the sign extension explicit rather than implied
    hse_acc_t dx_ext;
    hse_acc_t dy_ext;
    hse_acc_t dx_step;
    hse_acc_t dy_step;
    hse_acc_t row_term [`HSE_GRID];
    hse_acc_t col_term [`HSE_GRID];
    hse_acc_t site_val [`HSE_SITES];
    logic [`HSE_SITES-1:0] site_left;

    assign dx_ext = hse_acc_t'(link.dx);
    assign dy_ext = hse_acc_t'(link.dy);
    assign dx_step = dx_ext <<< `HSE_SUB_SHIFT;
    assign dy_step = dy_ext <<< `HSE_SUB_SHIFT;

    assign row_term[0] = '0;
    assign col_term[0] = '0;

    // Offsets 0, 8, 16, 24 are wired in as a chain of 8-delta additions,
    // so no multiplier sits in the site datapath:
    //   row_term holds 0, 8dx, 16dx, 24dx, one per site row
    //   col_term holds 0, 8dy, 16dy, 24dy, one per site column
    // The chain is three adders deep but only has to settle within the
    // load cycle; evaluations never pass through it
    genvar g;
    generate
        for (g = 1; g < `HSE_GRID; g++) begin : g_chain
            assign row_term[g] = row_term[g-1] + dx_step;
            assign col_term[g] = col_term[g-1] + dy_step;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Site array
    // ----------------------------------------------------------------

    // Site k sits at column k mod 4 and row k div 4 of the update array.
    // Every cell sees the same strobes and constant; only its site value
    // differs, so all sixteen cells stay identical copies
    genvar k;
    generate
        for (k = 0; k < `HSE_SITES; k++) begin : g_site
            localparam int ROW = k / `HSE_GRID;
            localparam int COL = k % `HSE_GRID;

            assign site_val[k] = row_term[ROW] - col_term[COL];

            hse_site u_site (
                .ref_clk_i(ref_clk_i),
                .rstn_i(rstn_i),
                .load_i(load_ok),
                .site_val_i(site_val[k]),
                .eval_i(eval_ok),
                .hconst_i(link.hconst),
                .left_o(site_left[k])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Edge state and evaluation bookkeeping
    // ----------------------------------------------------------------

    // Valid is recomputed every cycle, so it can never stick high; the
    // counter width is a parameter since a long strip of arrays can outrun it
    logic valid_q;
    logic valid_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    always_comb begin
        state_d = state_q;
        valid_d = eval_ok;
        cnt_d = cnt_q;
        if (load_ok) begin
            // Site values now stand until the next edge replaces them
            state_d = HSE_D_HELD;
            cnt_d = '0;
        end else if (eval_ok) begin
            // Counter wraps; it is a progress aid, not a limit
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= HSE_D_EMPTY;
            valid_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            valid_q <= valid_d;
            cnt_q <= cnt_d;
        end
    end

    // ----------------------------------------------------------------
    // Edge-held flag
    // ----------------------------------------------------------------

    // A flop of its own so the held output needs no decode of the state
    // register; it only ever rises, and only reset brings it back down,
    // because site values stay valid until the next edge replaces them.
    // The state register keeps qualifying evaluations on its own
    logic held_q;
    logic held_d;

    always_comb begin
        held_d = held_q;
        if (load_ok) begin
            held_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            held_q <= 1'b0;
        end else begin
            held_q <= held_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------

    // The mask comes straight from the sign flops inside the site cells
    // and holds its value between evaluations; bit k is the site in
    // column k mod 4, row k div 4, the same order as g_site.
    // The valid flag is high one cycle per accepted evaluation, so a host that needs the mask
    // later can read it at leisure until it evaluates again
    assign side_mask_o = site_left;
    assign side_valid_o = valid_q;
    assign edge_held_o = held_q;
    assign array_cnt_o = cnt_q;

    assign link.res_mask = site_left;
    assign link.res_valid = valid_q;
    assign link.held = held_q;

endmodule : hse_evaluator

// [logic/hse_host.sv]
// Rendering-processor end: edge setup, constant generation and update-array tiling
`timescale 1ns/1ps
`include "hse_consts.svh"

module hse_host #(
    parameter int TILE_W = 8
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    hse_link_if.host link,
    input wire logic start_i,
    input hse_pkg::hse_coord_t x1_i,
    input hse_pkg::hse_coord_t y1_i,
    input hse_pkg::hse_coord_t x2_i,
    input hse_pkg::hse_coord_t y2_i,
    input hse_pkg::hse_coord_t org_x_i,
    input hse_pkg::hse_coord_t org_y_i,
    input wire logic [TILE_W-1:0] cols_m1_i,
    input wire logic [TILE_W-1:0] rows_m1_i,
    output logic busy_o,
    output logic eval_o,
    output hse_pkg::hse_pix_t pix_x_o,
    output hse_pkg::hse_pix_t pix_y_o,
    output logic done_o
);
    import hse_pkg::*;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------

    hse_host_state_t st_q, st_d;
    hse_coord_t x1_q, x1_d, y1_q, y1_d, x2_q, x2_d, y2_q, y2_d;
    hse_coord_t bx_q, bx_d, ox_q, ox_d, oy_q, oy_d;
    logic [TILE_W-1:0] cols_q, cols_d, rows_q, rows_d, col_q, col_d, row_q, row_d;
    hse_delta_t dx_q, dx_d, dy_q, dy_d;
    hse_acc_t edge_q, edge_d, orig_q, orig_d, hconst_q, hconst_d;
    logic load_q, load_d, eval_q, eval_d, done_q, done_d;
    hse_pix_t px_q, px_d, py_q, py_d;
    hse_delta_t dx_c, dy_c;

    assign dx_c = hse_delta_t'(x2_q) - hse_delta_t'(x1_q);
    assign dy_c = hse_delta_t'(y2_q) - hse_delta_t'(y1_q);

    always_comb begin
        st_d = st_q;
        x1_d = x1_q;
        y1_d = y1_q;
        x2_d = x2_q;
        y2_d = y2_q;
        bx_d = bx_q;
        ox_d = ox_q;
        oy_d = oy_q;
        cols_d = cols_q;
        rows_d = rows_q;
        col_d = col_q;
        row_d = row_q;
        dx_d = dx_q;
        dy_d = dy_q;
        edge_d = edge_q;
        orig_d = orig_q;
        hconst_d = hconst_q;
        load_d = 1'b0;
        eval_d = 1'b0;
        done_d = 1'b0;
        px_d = px_q;
        py_d = py_q;
        unique case (st_q)
            HSE_H_IDLE: begin
                if (start_i) begin
                    x1_d = x1_i;
                    y1_d = y1_i;
                    x2_d = x2_i;
                    y2_d = y2_i;
                    // Origins snap to a pixel corner, the sampling point
                    bx_d = org_x_i & `HSE_SUB_MASK;
                    ox_d = org_x_i & `HSE_SUB_MASK;
                    oy_d = org_y_i & `HSE_SUB_MASK;
                    cols_d = cols_m1_i;
                    rows_d = rows_m1_i;
                    col_d = '0;
                    row_d = '0;
                    st_d = HSE_H_EDGE;
                end
            end
            HSE_H_EDGE: begin
                dx_d = dx_c;
                dy_d = dy_c;
                edge_d = hse_mul(hse_acc_t'(dy_c), hse_acc_t'(x1_q))
                    - hse_mul(hse_acc_t'(dx_c), hse_acc_t'(y1_q));
                st_d = HSE_H_LOAD;
            end
            HSE_H_LOAD: begin
                load_d = 1'b1;
                st_d = HSE_H_TERM;
            end
            HSE_H_TERM: begin
                orig_d = hse_mul(hse_acc_t'(dx_q), hse_acc_t'(oy_q))
                    - hse_mul(hse_acc_t'(dy_q), hse_acc_t'(ox_q));
                st_d = HSE_H_EVAL;
            end
            HSE_H_EVAL: begin
                hconst_d = orig_q + edge_q;
                eval_d = 1'b1;
                px_d = hse_pix_t'(ox_q >>> `HSE_SUB_SHIFT);
                py_d = hse_pix_t'(oy_q >>> `HSE_SUB_SHIFT);
                st_d = HSE_H_TERM;
                // Row-major walk of 4x4-pixel steps until the region is covered
                if (col_q == cols_q) begin
                    col_d = '0;
                    ox_d = bx_q;
                    if (row_q == rows_q) begin
                        done_d = 1'b1;
                        st_d = HSE_H_IDLE;
                    end else begin
                        row_d = row_q + 1'b1;
                        oy_d = oy_q + `HSE_ARRAY_SPAN;
                    end
                end else begin
                    col_d = col_q + 1'b1;
                    ox_d = ox_q + `HSE_ARRAY_SPAN;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q <= HSE_H_IDLE;
            x1_q <= '0;
            y1_q <= '0;
            x2_q <= '0;
            y2_q <= '0;
            bx_q <= '0;
            ox_q <= '0;
            oy_q <= '0;
            cols_q <= '0;
            rows_q <= '0;
            col_q <= '0;
            row_q <= '0;
            dx_q <= '0;
            dy_q <= '0;
            edge_q <= '0;
            orig_q <= '0;
            hconst_q <= '0;
            load_q <= 1'b0;
            eval_q <= 1'b0;
            done_q <= 1'b0;
            px_q <= '0;
            py_q <= '0;
        end else begin
            st_q <= st_d;
            x1_q <= x1_d;
            y1_q <= y1_d;
            x2_q <= x2_d;
            y2_q <= y2_d;
            bx_q <= bx_d;
            ox_q <= ox_d;
            oy_q <= oy_d;
            cols_q <= cols_d;
            rows_q <= rows_d;
            col_q <= col_d;
            row_q <= row_d;
            dx_q <= dx_d;
            dy_q <= dy_d;
            edge_q <= edge_d;
            orig_q <= orig_d;
            hconst_q <= hconst_d;
            load_q <= load_d;
            eval_q <= eval_d;
            done_q <= done_d;
            px_q <= px_d;
            py_q <= py_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------

    assign link.load = load_q;
    assign link.dx = dx_q;
    assign link.dy = dy_q;
    assign link.eval = eval_q;
    assign link.hconst = hconst_q;
    assign busy_o = (st_q != HSE_H_IDLE);
    assign eval_o = eval_q;
    assign pix_x_o = px_q;
    assign pix_y_o = py_q;
    assign done_o = done_q;

endmodule : hse_host

// [dv/hse_assertions.sv]
// Concurrent checks on the link between the processor end and the evaluator
`timescale 1ns/1ps

module hse_assertions (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic load,
    input hse_pkg::hse_delta_t dx,
    input hse_pkg::hse_delta_t dy,
    input wire logic eval,
    input hse_pkg::hse_acc_t hconst,
    input wire logic res_valid,
    input hse_pkg::hse_mask_t res_mask,
    input wire logic held
);
    import hse_pkg::*;

    hse_delta_t dx_q, dx_d, dy_q, dy_d;
    hse_mask_t exp_q, exp_d;
    hse_acc_t sum;
    logic take;

    // ----
    // Reference signs, built from the deltas held since the last load
    // ----
    assign take = eval && held && !load;

    always_comb begin
        dx_d = load ? dx : dx_q;
        dy_d = load ? dy : dy_q;
        exp_d = exp_q;
        sum = '0;
        for (int k = 0; k < 16; k++) begin
            sum = hse_acc_t'(dx_q) * (8 * (k / 4)) - hse_acc_t'(dy_q) * (8 * (k % 4)) + hconst;
            exp_d[k] = sum[35];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dx_q <= '0;
            dy_q <= '0;
            exp_q <= '0;
        end else begin
            dx_q <= dx_d;
            dy_q <= dy_d;
            exp_q <= exp_d;
        end
    end

    // ----
    // Assertions
    // ----
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    a_load_sets_held:
        assert property (load |=> held) else $error("held not set after load");
    a_held_sticks:
        assert property (held |=> held) else $error("held dropped without reset");
    a_eval_answered:
        assert property (take |=> res_valid) else $error("accepted eval not answered");
    a_no_stray_valid:
        assert property (!take |=> !res_valid) else $error("result without accepted eval");
    a_mask_holds:
        assert property (!res_valid |-> $stable(res_mask)) else $error("mask moved without result");
    a_mask_signs:
        assert property (res_valid |-> res_mask == exp_q) else $error("site signs wrong");
    a_eval_after_held:
        assert property (eval |-> held && !load) else $error("eval before edge loaded");
    a_eval_spacing:
        assert property (eval |=> !eval) else $error("constant not recomputed between arrays");
    a_load_gap:
        assert property (load |=> !eval && !load) else $error("eval right after load");

    c_all_left: cover property (res_valid && res_mask == 16'hffff);
    c_none_left: cover property (res_valid && res_mask == 16'h0000);
    c_split: cover property (res_valid && res_mask != 16'h0000 && res_mask != 16'hffff);
    c_reload: cover property (held && load);

endmodule : hse_assertions

// [dv/testbench.sv]
// Self-checking bench: host tiling plus a second evaluator driven directly
`timescale 1ns/1ps

module testbench;
    import hse_pkg::*;

    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic start_i = 1'b0;
    hse_coord_t x1, y1, x2, y2, org_x, org_y;
    logic [7:0] cols_m1, rows_m1;
    logic busy, h_eval, done, s_valid, held, s_valid_b, held_b;
    hse_pix_t pix_x, pix_y;
    hse_mask_t mask, mask_b, bmask;
    logic [15:0] cnt, cnt_b;
    longint bdx, bdy, sv;
    int bcnt, fail_count, n_checks;
    logic bheld;
    logic [31:0] seed = 32'h6f69;

    hse_link_if link_a ();
    hse_link_if link_b ();

    hse_host u_hse_host (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .link(link_a.host), .start_i(start_i),
        .x1_i(x1), .y1_i(y1), .x2_i(x2), .y2_i(y2), .org_x_i(org_x), .org_y_i(org_y), .cols_m1_i(cols_m1),
        .rows_m1_i(rows_m1), .busy_o(busy), .eval_o(h_eval), .pix_x_o(pix_x), .pix_y_o(pix_y), .done_o(done));
    hse_evaluator u_hse_evaluator (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .link(link_a.dev),
        .side_mask_o(mask), .side_valid_o(s_valid), .edge_held_o(held), .array_cnt_o(cnt));
    hse_evaluator u_hse_evaluator_b (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .link(link_b.dev),
        .side_mask_o(mask_b), .side_valid_o(s_valid_b), .edge_held_o(held_b), .array_cnt_o(cnt_b));
    hse_assertions u_hse_assertions (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .load(link_a.load),
        .dx(link_a.dx), .dy(link_a.dy), .eval(link_a.eval), .hconst(link_a.hconst),
        .res_valid(link_a.res_valid), .res_mask(link_a.res_mask), .held(link_a.held));

    always #2 ref_clk_i = ~ref_clk_i;

    // ----
    // Helpers
    // ----
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Bit set where the sample point falls strictly left of the directed edge
    function automatic hse_mask_t mdl(input longint dxv, dyv, ox, oy, c);
        hse_mask_t m;
        for (int k = 0; k < 16; k++) begin
            m[k] = ((oy + 8 * (k / 4)) * dxv - (ox + 8 * (k % 4)) * dyv + c) < 0;
        end
        return m;
    endfunction : mdl

    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    // One cycle on the direct link; idle lines carry inverted junk, not the last value
    task automatic step(input logic ld, ev, input hse_delta_t ddx, ddy, input hse_acc_t hc);
        logic acc;
        acc = ev && bheld && !ld;
        link_b.load = ld;
        link_b.dx = ld ? ddx : ~link_b.dx;
        link_b.dy = ld ? ddy : ~link_b.dy;
        link_b.eval = ev;
        link_b.hconst = ev ? hc : ~link_b.hconst;
        if (acc) begin
            bmask = mdl(bdx, bdy, 0, 0, hc);
            bcnt++;
        end
        if (ld) begin
            bdx = ddx;
            bdy = ddy;
            bcnt = 0;
            bheld = 1'b1;
        end
        @(posedge ref_clk_i);
        #1;
        chk("valid_b", s_valid_b, acc);
        chk("mask_b", mask_b, bmask);
        chk("held_b", held_b, bheld);
        chk("count_b", cnt_b, bcnt);
    endtask : step

    // Start held high while busy: a second start must be ignored
    task automatic run_tile(input hse_coord_t ax1, ay1, ax2, ay2, ox0, oy0, input logic [7:0] c, r);
        longint ox, oy;
        int i, tot, guard;
        logic pend;
        hse_mask_t em;
        x1 = ax1;
        y1 = ay1;
        x2 = ax2;
        y2 = ay2;
        org_x = ox0;
        org_y = oy0;
        cols_m1 = c;
        rows_m1 = r;
        start_i = 1'b1;
        tot = (c + 1) * (r + 1);
        i = 0;
        pend = 1'b0;
        em = '0;
        for (guard = 0; guard < 40 * tot && (i < tot || pend); guard++) begin
            @(posedge ref_clk_i);
            #1;
            chk("valid", s_valid, pend);
            if (pend) begin
                chk("mask", mask, em);
                chk("count", cnt, i);
            end
            chk("eval", h_eval, guard == 4 + 2 * i);
            chk("busy", busy, guard < 2 + 2 * tot);
            pend = h_eval;
            if (h_eval) begin
                ox = (longint'(ox0) >>> 3) * 8 + 32 * (i % (c + 1));
                oy = (longint'(oy0) >>> 3) * 8 + 32 * (i / (c + 1));
                chk("pix_x", pix_x, hse_pix_t'(ox >>> 3));
                chk("pix_y", pix_y, hse_pix_t'(oy >>> 3));
                chk("done", done, i == tot - 1);
                em = mdl(longint'(ax2) - ax1, longint'(ay2) - ay1, ox - ax1, oy - ay1, 0);
                i++;
                if (i == tot) start_i = 1'b0;
            end
        end
        start_i = 1'b0;
        chk("arrays", i, tot);
        if (i != tot) test_done();
    endtask : run_tile

    // ----
    // Main sequence
    // ----
    initial begin
        {x1, y1, x2, y2, org_x, org_y, cols_m1, rows_m1} = '0;
        {link_b.load, link_b.dx, link_b.dy, link_b.eval, link_b.hconst} = '0;
        {fail_count, n_checks, bcnt, bdx, bdy} = '0;
        bheld = 1'b0;
        bmask = '0;
        repeat (2) @(posedge ref_clk_i);
        #1;
        rstn_i = 1'b1;
        chk("held_rst", held, 1'b0);
        step(1'b0, 1'b1, '0, '0, 36'sh123);
        step(1'b1, 1'b0, hse_delta_t'($signed(16'(rnd()))), hse_delta_t'($signed(16'(rnd()))), '0);
        step(1'b1, 1'b1, 17'sh0ffff, 17'sh10001, 36'sh5);
        for (int n = 0; n < 24; n++) begin
            step(1'b0, 1'b1, '0, '0, hse_acc_t'(longint'($signed(rnd())) * 4));
        end
        step(1'b1, 1'b0, hse_delta_t'($signed(16'(rnd()))), hse_delta_t'($signed(16'(rnd()))), '0);
        for (int k = 0; k < 16; k++) begin
            sv = 8 * (k / 4) * bdx - 8 * (k % 4) * bdy;
            step(1'b0, 1'b1, '0, '0, hse_acc_t'(-sv));
            step(1'b0, 1'b1, '0, '0, hse_acc_t'(-sv - 1));
        end
        step(1'b0, 1'b0, '0, '0, '0);
        $display("direct evaluator test done");
        run_tile(16'sh0040, 16'sh0000, 16'sh0000, 16'sh0000, 16'sh0000, 16'sh0000, 8'h01, 8'h00);
        run_tile(16'sh8000, 16'sh8000, 16'sh7fff, 16'sh7fff, 16'shffd3, 16'shffd8, 8'h02, 8'h01);
        run_tile(16'sh7fff, 16'sh8000, 16'sh8000, 16'sh7fff, 16'sh7f00, 16'sh8000, 8'h00, 8'h00);
        for (int n = 0; n < 8; n++) begin
            run_tile(hse_coord_t'(rnd()), hse_coord_t'(rnd()), hse_coord_t'(rnd()), hse_coord_t'(rnd()),
                hse_coord_t'($signed(15'(rnd()))), hse_coord_t'($signed(15'(rnd()))), 8'(rnd() % 4),
                8'(rnd() % 4));
        end
        $display("tiling test done");
        test_done();
    end

endmodule : testbench
